// file: design/lcd_pkg.sv
// constants for the serial lcd command decoder
// assumes one core clock; serial link and source clock pins arrive asynchronously, apb pins are synchronous
package lcd_pkg;
    localparam int RAM_WORDS = 32;
    localparam int ADDR_W = 6;
    localparam int APB_AW = 8;
    // mode prefixes
    localparam logic [2:0] PFX_READ = 3'h6;
    localparam logic [2:0] PFX_WRITE = 3'h5;
    localparam logic [2:0] PFX_CMD = 3'h4;
    // last bit index of each field (length minus one), command X bit included
    localparam logic [3:0] CMD_LAST = 4'h8;
    localparam logic [3:0] ADDR_LAST = 4'h5;
    localparam logic [3:0] NIB_LAST = 4'h3;
    localparam logic [3:0] PFX_LAST = 4'h2;
    // system clock sources
    localparam logic [1:0] SRC_XTAL = 2'h1;
    localparam logic [1:0] SRC_RC = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;
    // source rates and derived division counts
    localparam int RC_HZ = 256000;
    localparam int XTAL_HZ = 32768;
    localparam int BASE_HZ = 256;
    localparam int TONE_HI_HZ = 4000;
    localparam int TONE_LO_HZ = 2000;
    localparam logic [15:0] RC_BASE_DIV = 16'(RC_HZ / BASE_HZ);
    localparam logic [15:0] XT_BASE_DIV = 16'(XTAL_HZ / BASE_HZ);
    localparam logic [15:0] RC_HI_DIV = 16'(RC_HZ / (2 * TONE_HI_HZ));
    localparam logic [15:0] RC_LO_DIV = 16'(RC_HZ / (2 * TONE_LO_HZ));
    localparam logic [15:0] XT_HI_DIV = 16'(XTAL_HZ / (2 * 4096));
    localparam logic [15:0] XT_LO_DIV = 16'(XTAL_HZ / (2 * 2048));
    // watchdog flag after this many time base periods
    localparam logic [2:0] WD_PERIODS = 3'h4;
    // power-on defaults
    localparam logic [2:0] RATE_RESET = 3'h7;
    localparam logic [1:0] COM_RESET = 2'h2;
    // apb map
    localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
    localparam int CTRL_LINK_EN = 0;
    localparam int CTRL_WD_CLR = 1;
    // synchroniser bit positions
    localparam int PIN_CS = 0;
    localparam int PIN_WR = 1;
    localparam int PIN_RD = 2;
    localparam int PIN_DAT = 3;
    localparam int PIN_SRC = 4;
    typedef enum logic [4:0] {
        ST_PREFIX = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_WRITE = 5'b00100,
        ST_READ = 5'b01000,
        ST_CMD = 5'b10000
    } lcd_state_t;
endpackage

// file: design/lcd_serial_command_decoder.sv
// serial command and data decoder of a 32x4 segment lcd controller
// assumes pins arrive asynchronously to core_clk and are much slower
//
// How it works
// RULE1: prefix 110, address msb first, nibble out lsb first
// RULE2: prefix 101, address, nibble lsb first stored
// RULE3: 101 plus read clock returns nibble, then rewrite
// RULE4: prefix 100, later words are commands directly
// RULE5: system disable stops oscillator and bias
// RULE6: system enable starts oscillator
// RULE7: display off and on steer bias generator
// RULE8: timer disable and enable gate time base; here they only gate its irq output, the counter keeps running
// RULE9: watchdog disable and enable gate flag output
// RULE10: tone off and on gate buzzer outputs
// RULE11: clear pattern resets time base counter
// RULE12: clear pattern resets watchdog stage
// RULE13: command word selects system clock source
// RULE14: configuration word sets bias and commons
// RULE15: tone frequency words pick 4 or 2 kHz
// RULE16: rate field picks 1 to 128 Hz
// RULE17: watchdog flag after four rate periods
// RULE18: test word enters test, normal word leaves
// RULE19: reset loads the power-on defaults
// RULE20: divisions follow the selected clock source
// RULE21: host should send full init after power-up
// RULE22: interrupt output disable and enable words
// RULE23: bits sampled on write clock rising edge
// RULE24: read bits driven on read clock falling edge
// RULE25: chip select high aborts and resets mode
`timescale 1ns/10ps
module lcd_serial_command_decoder
    import lcd_pkg::*;
#(
    parameter int RAM_DEPTH = RAM_WORDS
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lcd_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chipSelN,
    input wire logic writeClk,
    input wire logic readClk,
    input wire logic dataIn,
    output logic dataOut,
    output logic dataOe,
    input wire logic sourceClk,
    output logic buzzer_out,
    output logic buzzer_outN,
    output logic irqN,
    output logic sysOscEn,
    output logic biasEn,
    output logic biasThird,
    output logic [1:0] comSel,
    output logic [1:0] clkSrc,
    output logic testMode
);
    import lcd_pkg::*;

    if (RAM_DEPTH != RAM_WORDS)
    begin : g_bad_depth
        $error("ram depth must be 32 nibbles");
    end

    function automatic logic [15:0] srcDiv(input logic [1:0] src,
            input logic [15:0] rcVal, input logic [15:0] xtVal);
        srcDiv = (src == SRC_XTAL) ? xtVal : rcVal;
    endfunction

    logic [4:0] syncA;
    logic [4:0] syncB;
    logic wrPrev;
    logic rdPrev;
    logic srcPrev;
    lcd_state_t state;
    logic [3:0] bitCnt;
    logic [1:0] rdCnt;
    logic [8:0] shiftReg;
    logic [ADDR_W-1:0] ram_address_bits;
    logic [2:0] ram_nibble_bits;
    logic readMode;
    logic rmwRead;
    logic [3:0] ram [RAM_WORDS];
    logic linkEnable;
    logic timebaseEn;
    logic watchdogEn;
    logic toneEn;
    logic toneHigh;
    logic irqEn;
    logic [2:0] rateSel;
    logic [15:0] baseCnt;
    logic [7:0] tbCnt;
    logic tbPrev;
    logic [2:0] wdCnt;
    logic wdFlag;
    logic [15:0] toneCnt;
    logic toneWave;

    // pin synchronisers
    always_ff @(posedge core_clk)
    begin
        syncA <= {sourceClk, dataIn, readClk, writeClk, chipSelN};
        syncB <= syncA;
        wrPrev <= syncB[PIN_WR];
        rdPrev <= syncB[PIN_RD];
        srcPrev <= syncB[PIN_SRC];
    end

    wire selected = ~syncB[PIN_CS] & linkEnable;
    wire wrRise = syncB[PIN_WR] & ~wrPrev; // RULE23
    wire rdFall = ~syncB[PIN_RD] & rdPrev; // RULE24
    wire srcRise = syncB[PIN_SRC] & ~srcPrev;
    wire din = syncB[PIN_DAT];
    wire [2:0] prefix = {shiftReg[1:0], din};
    wire [4:0] ramIdx = ram_address_bits[4:0];
    wire takeBit = selected & wrRise;
    wire ramWe = takeBit & (state == ST_WRITE) & (bitCnt == NIB_LAST);
    wire cmdDone = takeBit & (state == ST_CMD) & (bitCnt == CMD_LAST);
    wire [7:0] cmdWord = shiftReg[7:0];

    // serial front end
    always_ff @(posedge core_clk)
    begin
        if (rst || !selected)
        begin
            state <= ST_PREFIX; // RULE25
            bitCnt <= 4'h0;
            rdCnt <= 2'h0;
            rmwRead <= 1'b0;
            readMode <= 1'b0;
        end
        else if (wrRise)
        begin
            shiftReg <= {shiftReg[7:0], din};
            bitCnt <= bitCnt + 4'h1;
            case (state)
                ST_PREFIX:
                begin
                    if (bitCnt == PFX_LAST)
                    begin
                        bitCnt <= 4'h0;
                        readMode <= (prefix == PFX_READ); // RULE1
                        if (prefix == PFX_READ || prefix == PFX_WRITE) // RULE2
                            state <= ST_ADDR;
                        else if (prefix == PFX_CMD) // RULE4
                            state <= ST_CMD;
                    end
                end
                ST_ADDR:
                begin
                    ram_address_bits <= {ram_address_bits[ADDR_W-2:0], din}; // RULE1
                    if (bitCnt == ADDR_LAST)
                    begin
                        bitCnt <= 4'h0;
                        state <= readMode ? ST_READ : ST_WRITE;
                    end
                end
                ST_WRITE:
                begin
                    // host owns the line again once write bits start
                    rmwRead <= 1'b0; // RULE3
                    if (bitCnt != NIB_LAST)
                        ram_nibble_bits[bitCnt[1:0]] <= din; // RULE2
                    if (bitCnt == NIB_LAST)
                    begin
                        bitCnt <= 4'h0;
                        rdCnt <= 2'h0;
                        ram_address_bits <= ram_address_bits + 6'h01;
                    end
                end
                ST_CMD:
                begin
                    if (bitCnt == CMD_LAST)
                        bitCnt <= 4'h0; // RULE4
                end
                ST_READ:
                    bitCnt <= 4'h0;
                default:
                    state <= ST_PREFIX;
            endcase
        end
        else if (rdFall && (state == ST_READ || state == ST_WRITE))
        begin
            rdCnt <= rdCnt + 2'h1; // RULE24
            if (state == ST_WRITE)
                rmwRead <= 1'b1; // RULE3
            else if (rdCnt == NIB_LAST[1:0])
                ram_address_bits <= ram_address_bits + 6'h01; // RULE1
        end
    end

    // display memory
    always_ff @(posedge core_clk)
    begin
        if (ramWe)
            ram[ramIdx] <= {din, ram_nibble_bits}; // RULE2
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            dataOut <= 1'b0;
        else if (rdFall)
            dataOut <= ram[ramIdx][rdCnt]; // RULE3
    end

    assign dataOe = selected & ((state == ST_READ) | ((state == ST_WRITE) & rmwRead));

    // command word decode
    wire isSys = cmdDone & (cmdWord[7:4] == 4'h0);
    wire isSysDis = isSys & (cmdWord[3:0] == 4'h0);
    wire isSysEn = isSys & (cmdWord[3:0] == 4'h1);
    wire isBias = isSys & (cmdWord[3:1] == 3'h1);
    wire isTimer = isSys & (cmdWord[3:2] == 2'h1) & ~cmdWord[0];
    wire isWatch = isSys & (cmdWord[3:2] == 2'h1) & cmdWord[0];
    wire isTone = isSys & (cmdWord[3:1] == 3'h4);
    wire isTbClr = isSys & (cmdWord[3:2] == 2'h3);
    wire isWdClr = isSys & (cmdWord[3:1] == 3'h7);
    wire isSrc = cmdDone & (cmdWord[7:4] == 4'h1) & (cmdWord[3:2] != 2'h0);
    wire isLcdCfg = cmdDone & (cmdWord[7:4] == 4'h2) & (cmdWord[3:2] != 2'h3);
    wire isFreq = cmdDone & (cmdWord[7:6] == 2'h1);
    wire isIrq = cmdDone & (cmdWord[7:5] == 3'h4);
    wire isRate = cmdDone & (cmdWord[7:5] == 3'h5);
    wire isTest = cmdDone & (cmdWord == 8'hE0);
    wire isNormal = cmdDone & (cmdWord == 8'hE3);
    wire apbWrite = psel & penable & pwrite;
    wire apbWdClr = apbWrite & (paddr == REG_CTRL) & pwdata[CTRL_WD_CLR];

    // configuration state
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sysOscEn <= 1'b0; // RULE19
            biasEn <= 1'b0;
            timebaseEn <= 1'b0;
            watchdogEn <= 1'b0;
            toneEn <= 1'b0;
            toneHigh <= 1'b0;
            clkSrc <= SRC_RC;
            biasThird <= 1'b0;
            comSel <= COM_RESET;
            irqEn <= 1'b0;
            rateSel <= RATE_RESET;
            testMode <= 1'b0;
        end
        else
        begin
            if (isSysDis)
            begin
                sysOscEn <= 1'b0; // RULE5
                biasEn <= 1'b0;
            end
            if (isSysEn)
                sysOscEn <= 1'b1; // RULE6
            if (isBias)
                biasEn <= cmdWord[0]; // RULE7
            if (isTimer)
                timebaseEn <= cmdWord[1]; // RULE8
            if (isWatch)
                watchdogEn <= cmdWord[1]; // RULE9
            if (isTone)
                toneEn <= cmdWord[0]; // RULE10
            if (isSrc)
                clkSrc <= cmdWord[3:2]; // RULE13
            if (isLcdCfg)
            begin
                biasThird <= cmdWord[0]; // RULE14
                comSel <= cmdWord[3:2];
            end
            if (isFreq)
                toneHigh <= ~cmdWord[5]; // RULE15
            if (isIrq)
                irqEn <= cmdWord[3]; // RULE22
            if (isRate)
                rateSel <= cmdWord[2:0]; // RULE16
            if (isTest)
                testMode <= 1'b1; // RULE18
            if (isNormal)
                testMode <= 1'b0;
        end
    end

    // time base and watchdog; external source ignores system disable
    wire running = sysOscEn | (clkSrc == SRC_EXT);
    wire [15:0] baseDiv = srcDiv(clkSrc, RC_BASE_DIV, XT_BASE_DIV); // RULE20
    wire baseTick = running & srcRise & (baseCnt >= baseDiv - 16'h0001);
    wire [2:0] tbSel = 3'h7 - rateSel;
    wire tbWave = tbCnt[tbSel]; // RULE16
    wire tbEdge = tbWave & ~tbPrev;

    always_ff @(posedge core_clk)
    begin
        if (rst || isTbClr)
        begin
            baseCnt <= 16'h0000; // RULE11
            tbCnt <= 8'h00;
        end
        else if (running && srcRise)
        begin
            baseCnt <= baseTick ? 16'h0000 : baseCnt + 16'h0001;
            tbCnt <= tbCnt + {7'h00, baseTick};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            tbPrev <= 1'b0;
        else
            tbPrev <= tbWave;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wdCnt <= 3'h0;
            wdFlag <= 1'b0;
        end
        else if (tbEdge && !wdFlag && wdCnt == WD_PERIODS - 3'h1)
        begin
            wdCnt <= wdCnt + 3'h1; // set wins over a clear in the same cycle
            wdFlag <= 1'b1;
        end
        else if (isWdClr || apbWdClr)
        begin
            wdCnt <= 3'h0; // RULE12
            wdFlag <= 1'b0;
        end
        else if (tbEdge && !wdFlag)
        begin
            wdCnt <= wdCnt + 3'h1; // RULE17
            wdFlag <= (wdCnt == WD_PERIODS - 3'h1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            irqN <= 1'b1;
        else
            irqN <= ~(irqEn & ((timebaseEn & tbWave) | (watchdogEn & wdFlag))); // RULE22
    end

    // tone generator
    wire [15:0] toneDiv = toneHigh ? srcDiv(clkSrc, RC_HI_DIV, XT_HI_DIV)
                                   : srcDiv(clkSrc, RC_LO_DIV, XT_LO_DIV); // RULE20
    wire toneOn = toneEn & running;

    always_ff @(posedge core_clk)
    begin
        if (rst || !toneOn)
        begin
            toneCnt <= 16'h0000;
            toneWave <= 1'b0;
        end
        else if (srcRise)
        begin
            if (toneCnt >= toneDiv - 16'h0001)
            begin
                toneCnt <= 16'h0000;
                toneWave <= ~toneWave; // RULE15
            end
            else
                toneCnt <= toneCnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            buzzer_out <= 1'b0;
            buzzer_outN <= 1'b0;
        end
        else
        begin
            buzzer_out <= toneOn & toneWave; // RULE10
            buzzer_outN <= toneOn & ~toneWave;
        end
    end

    // apb slave
    wire hitCtrl = (paddr == REG_CTRL);
    wire hitStatus = (paddr == REG_STATUS);
    wire [31:0] statusWord = {12'h000, state == ST_PREFIX, wdFlag, testMode,
        rateSel, irqEn, comSel, biasThird, clkSrc, toneHigh, toneEn,
        watchdogEn, timebaseEn, biasEn, sysOscEn};

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hitCtrl | hitStatus);

    always_ff @(posedge core_clk)
    begin
        if (rst)
            linkEnable <= 1'b1;
        else if (apbWrite && hitCtrl)
            linkEnable <= pwdata[CTRL_LINK_EN];
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= hitStatus ? statusWord
                    : hitCtrl ? {31'h0000_0000, linkEnable} : 32'h0000_0000;
    end
endmodule // lcd_serial_command_decoder

// file: tb/lcd_checker.sv
// assertions on the decoder pins
// bound to the decoder top, one clock
`timescale 1ns/10ps
module lcd_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic chipSelN,
    input wire logic readClk,
    input wire logic dataOut,
    input wire logic dataOe,
    input wire logic buzzer_out,
    input wire logic buzzer_outN,
    input wire logic irqN,
    input wire logic sysOscEn,
    input wire logic biasEn,
    input wire logic biasThird,
    input wire logic [1:0] comSel,
    input wire logic [1:0] clkSrc,
    input wire logic testMode
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_reset_defaults: assert property ($fell(rst) |-> !sysOscEn && !biasEn && irqN
        && !testMode && !biasThird && comSel == 2'h2 && clkSrc == 2'h2 && !dataOe)
        else $error("reset defaults wrong");
    a_buzz_diff: assert property (!(buzzer_out && buzzer_outN))
        else $error("buzzer outputs both high");
    a_buzz_sysoff: assert property (!sysOscEn [*4] |-> !buzzer_out && !buzzer_outN)
        else $error("buzzer active while system off");
    a_bias_sysdis: assert property ($fell(sysOscEn) |-> ##[0:1] !biasEn)
        else $error("bias kept after system disable");
    a_cs_oe: assert property (chipSelN [*5] |-> !dataOe)
        else $error("data driven while deselected");
    a_read_hold: assert property (readClk [*5] |=> $stable(dataOut))
        else $error("read data moved without read clock fall");
    a_cfg_selected: assert property ($changed({sysOscEn, biasEn, biasThird, comSel, clkSrc,
        testMode}) |-> !chipSelN)
        else $error("config changed while deselected");
    a_src_legal: assert property (clkSrc != 2'h0)
        else $error("clock source code illegal");
endmodule // lcd_checker
bind lcd_serial_command_decoder lcd_checker chk_u (.core_clk(core_clk), .rst(rst),
    .chipSelN(chipSelN), .readClk(readClk), .dataOut(dataOut), .dataOe(dataOe),
    .buzzer_out(buzzer_out), .buzzer_outN(buzzer_outN), .irqN(irqN), .sysOscEn(sysOscEn),
    .biasEn(biasEn), .biasThird(biasThird), .comSel(comSel), .clkSrc(clkSrc),
    .testMode(testMode));

// file: tb/lcd_host_model.sv
// host side of the four-wire serial link
// assumes the decoder splits the data pin into in, out and enable
`timescale 1ns/10ps
module lcd_host_model (
    output logic chipSelN,
    output logic writeClk,
    output logic readClk,
    output logic dataIn,
    input wire logic dataOut,
    input wire logic dataOe
);
    logic hostBit;
    logic hostOe;
    // released line shows the inverse of its last value
    assign dataIn = hostOe ? hostBit : (dataOe ? dataOut : ~hostBit);
    initial
    begin
        chipSelN = 1'b1;
        writeClk = 1'b1;
        readClk = 1'b1;
        hostBit = 1'b0;
        hostOe = 1'b0;
    end
    task automatic open_frame();
        chipSelN = 1'b0;
        #320;
    endtask
    task automatic close_frame();
        #320;
        hostOe = 1'b0;
        chipSelN = 1'b1;
        #640;
    endtask
    // msb first; prefix, address and commands
    task automatic send_bits(input logic [23:0] val, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            writeClk = 1'b0;
            hostBit = val[i];
            hostOe = 1'b1;
            #160;
            writeClk = 1'b1;
            #160;
        end
    endtask
    task automatic read_nibble(output logic [3:0] nib);
        hostOe = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            readClk = 1'b0;
            #160;
            readClk = 1'b1;
            #150;
            nib[i] = dataIn;
            #10;
        end
    endtask
endmodule // lcd_host_model

// file: tb/lcd_serial_command_decoder_tb.sv
// bench for the serial lcd decoder
// assumes host model and checker are compiled first
`timescale 1ns/10ps
module lcd_serial_command_decoder_tb;
    import lcd_pkg::*;
    logic core_clk, rst, psel, penable, pwrite, sourceClk;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, chipSelN, writeClk, readClk, dataIn, dataOut, dataOe;
    logic buzzer_out, buzzer_outN, irqN, sysOscEn, biasEn, biasThird, testMode;
    logic [1:0] comSel, clkSrc;
    int errorCnt, checksDone;
    lcd_serial_command_decoder dut_u (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chipSelN(chipSelN), .writeClk(writeClk),
        .readClk(readClk), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .sourceClk(sourceClk), .buzzer_out(buzzer_out), .buzzer_outN(buzzer_outN),
        .irqN(irqN), .sysOscEn(sysOscEn), .biasEn(biasEn), .biasThird(biasThird),
        .comSel(comSel), .clkSrc(clkSrc), .testMode(testMode));
    lcd_host_model host_u (.chipSelN(chipSelN), .writeClk(writeClk), .readClk(readClk),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial
    begin
        sourceClk = 1'b0;
        forever #1953 sourceClk = ~sourceClk;
    end
    task automatic reportAndStop();
        $display("errors %0d checks %0d", errorCnt, checksDone);
        if (errorCnt == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            errorCnt++;
            reportAndStop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic status_is(input logic [15:0] m, input logic [15:0] e);
        logic [31:0] d;
        logic er;
        apb(1'b0, REG_STATUS, 32'h0, d, er);
        chk(d & {16'h0, m}, {16'h0, e});
    endtask
    task automatic cmd(input logic [7:0] c);
        host_u.open_frame();
        host_u.send_bits({PFX_CMD, c, 1'b0}, 12);
        host_u.close_frame();
    endtask
    task automatic chain(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        host_u.open_frame();
        host_u.send_bits({PFX_CMD, a, 1'b0, b, 1'b0}, 21);
        host_u.send_bits({c, 1'b0}, 9);
        host_u.close_frame();
    endtask
    task automatic t_reset();
        logic [31:0] d;
        logic e;
        status_is(16'hFFFF, 16'h7480);
        chk({22'h0, irqN, sysOscEn, biasEn, biasThird, comSel, clkSrc, testMode, buzzer_outN},
            32'h228);
        apb(1'b1, 8'h40, 32'h1, d, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h40, 32'h0, d, e);
        chk({d[30:0], e}, 32'h1);
        apb(1'b1, REG_CTRL, 32'h3, d, e);
        apb(1'b0, REG_CTRL, 32'h0, d, e);
        chk(d & 32'h1, 32'h1);
    endtask
    task automatic t_cmds();
        logic [39:0] tbl[25] = '{40'h01_0001_0001, 40'h03_0002_0002, 40'h06_0004_0004,
            40'h07_0008_0008, 40'h09_0010_0010, 40'h5F_0020_0020, 40'h60_0020_0000,
            40'h17_00C0_0040, 40'h1C_00C0_00C0, 40'h1A_00C0_0080, 40'h29_0700_0500,
            40'h26_0700_0200, 40'h22_0700_0000, 40'h88_0800_0800, 40'h97_0800_0000,
            40'hA0_7000_0000, 40'hBB_7000_3000, 40'hA7_7000_7000, 40'hE0_8000_8000,
            40'hE3_8000_0000, 40'h04_0004_0000, 40'h05_0008_0000, 40'h08_0010_0000,
            40'h02_0002_0000, 40'h00_0001_0000};
        foreach (tbl[i])
        begin
            cmd(tbl[i][39:32]);
            status_is(tbl[i][31:16], tbl[i][15:0]);
        end
    endtask
    task automatic t_ram();
        logic [3:0] n0, n1;
        host_u.open_frame();
        host_u.send_bits({PFX_WRITE, 6'h1E, 4'h3, 4'hC}, 17);
        host_u.close_frame();
        host_u.open_frame();
        host_u.send_bits({PFX_WRITE, 6'h1E}, 9);
        host_u.read_nibble(n0);
        host_u.send_bits(24'hA, 4);
        host_u.close_frame();
        chk({28'h0, n0}, 32'hC);
        host_u.open_frame();
        host_u.send_bits({PFX_WRITE, 6'h1E, 2'h3}, 11);
        host_u.close_frame();
        host_u.open_frame();
        host_u.send_bits({PFX_CMD, 4'h0}, 7);
        host_u.close_frame();
        host_u.open_frame();
        host_u.send_bits({PFX_READ, 6'h1E}, 9);
        host_u.read_nibble(n0);
        host_u.read_nibble(n1);
        host_u.close_frame();
        chk({24'h0, n1, n0}, 32'h35);
    endtask
    task automatic count_tone(input int lo, input int hi);
        int cnt;
        logic prev;
        cnt = 0;
        prev = buzzer_out;
        repeat (25000)
        begin
            @(posedge core_clk);
            if (buzzer_out && !prev)
                cnt++;
            prev = buzzer_out;
        end
        chk(32'(cnt >= lo && cnt <= hi), 32'h1);
    endtask
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        errorCnt = 0;
        checksDone = 0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        chain(8'h01, 8'h03, 8'h09);
        status_is(16'h0013, 16'h0013);
        cmd(8'h00);
        status_is(16'h0003, 16'h0000);
        t_cmds();
        t_ram();
        chain(8'h01, 8'h09, 8'h40);
        count_tone(3, 5);
        cmd(8'h60);
        count_tone(1, 3);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        reportAndStop();
    end
    initial
    begin
        #4000000;
        errorCnt++;
        reportAndStop();
    end
endmodule // lcd_serial_command_decoder_tb
